// ---- core/flash_hub_pin_control.sv ----
// Operation
// - Either reset pin low resets whole device
// - Four straps set identity; boot is 0000
// - Five general inputs readable via snapshot register
// - Top lock low refuses boot sector writes in hub mode
// - Write guard low refuses other block writes in hub mode
// - Row/column select steers factory address pins
// - Answer cycle only when target nibble matches
// - Interface select high: factory; fixed at reset
module flash_hub_pin_control
  import hub_pin_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_main_reset_n,
  input  wire logic                i_init_n,
  input  wire logic [3:0]          i_strap_select,
  input  wire logic [4:0]          i_general_inputs,
  input  wire logic                i_top_sector_lock_n,
  input  wire logic                i_write_guard_n,
  input  wire logic                i_interface_select,
  input  wire logic                i_row_col_select,
  input  wire logic [ROW_W-1:0]    i_addr_pins,
  input  wire logic                i_frame_strobe_n,
  input  wire logic [3:0]          i_nibble_bus,
  input  wire logic                i_prog_valid,
  input  wire logic [ARRAY_AW-1:0] i_prog_addr,
  input  wire logic [REG_AW-1:0]   i_reg_addr,
  input  wire logic [REG_DW-1:0]   i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [REG_DW-1:0]   o_reg_rdata,
  output logic                     o_int_rst,
  output logic                     o_factory_mode,
  output logic                     o_cycle_selected,
  output logic                     o_write_start,
  output logic                     o_write_blocked,
  output logic      [ARRAY_AW-1:0] o_write_addr,
  output logic      [ARRAY_AW-1:0] o_pp_address
);

  // Raw pins gathered into one bundle
  pins_s                 pins_raw;
  // Synchroniser stages; stage 1 is read only by stage 2
  pins_s                 sync_s1;
  pins_s                 sync_s2;
  pins_s                 sync_s3;
  // Filtered pin levels, updated once stages 2 and 3 agree
  pins_s                 pins;
  // Combined internal reset
  logic                  int_rst;
  // Mode caught while reset is held
  logic                  factory_mode;
  // Hub-bus decoder state
  bus_state_e            bus_state;
  logic [4:0]            field_left;
  logic                  selected;
  // Software registers
  logic [REG_DW-1:0]     control;
  logic [1:0]            events;
  logic [REG_DW-1:0]     snapshot;
  logic [REG_DW-1:0]     status;
  // Protection decode
  logic                  in_top_block;
  logic                  prog_refused;
  prog_req_s             prog_req;
  // Factory address halves
  logic [ROW_W-1:0]      row_part;
  logic [COL_W-1:0]      col_part;

  assign pins_raw = '{
    main_reset_n:      i_main_reset_n,
    init_n:            i_init_n,
    strap_select:      i_strap_select,
    general_inputs:    i_general_inputs,
    top_sector_lock_n: i_top_sector_lock_n,
    write_guard_n:     i_write_guard_n,
    interface_select:  i_interface_select,
    row_col_select:    i_row_col_select,
    addr_pins:         i_addr_pins
  };

  assign prog_req = '{valid: i_prog_valid, addr: i_prog_addr};

  // Three-stage pin synchroniser, one chain per pin bit
  genvar b;
  generate
    for (b = 0; b < PIN_W; b++) begin : g_sync
      // Stages carry no reset so reset pins themselves keep passing
      always_ff @(posedge i_clk) begin
        sync_s1[b] <= pins_raw[b];
        sync_s2[b] <= sync_s1[b];
        sync_s3[b] <= sync_s2[b];
      end

      // Accept a change only when the two late stages agree
      // Costs a cycle of latency but rejects one-cycle glitches
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          // Follow the pins in reset so the mode latch sees real levels
          pins[b] <= sync_s3[b];
        end else if (sync_s2[b] == sync_s3[b]) begin
          pins[b] <= sync_s3[b];
        end
      end
    end
  endgenerate

  // Either reset pin drives the same int_rst as the system reset, but only i_rst makes the pin filter follow stage 3
  // Combinational so a pin reset reaches every block at once
  assign int_rst   = i_rst | ~pins.main_reset_n | ~pins.init_n;
  assign o_int_rst = int_rst;

  // Interface mode is sampled only while reset is held, then frozen
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      factory_mode <= pins.interface_select;
    end
  end

  // Mode keeps its reset-time level until the next reset
  assign o_factory_mode = factory_mode;

  // Hub-bus target decode
  // Only the last start field before the strobe rises counts
  // Strobe and nibble share this clock, so they skip the pin filter
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      bus_state  <= BUS_IDLE;
      field_left <= '0;
      selected   <= 1'b0;
    end else if (!i_frame_strobe_n && i_nibble_bus == START_CODE) begin
      // A fresh start always restarts the decode
      bus_state  <= BUS_TARGET;
      field_left <= '0;
      selected   <= 1'b0;
    end else begin
      unique case (bus_state)
        BUS_IDLE: begin
          selected <= 1'b0;
        end
        BUS_TARGET: begin
          // Answer the whole cycle only on an identity match
          if (!factory_mode && control[CT_RESPOND_BIT] &&
              i_nibble_bus == pins.strap_select) begin
            bus_state  <= BUS_ACTIVE;
            field_left <= CYCLE_REST;
            selected   <= 1'b1;
          end else begin
            // Other identities: stay silent until next start
            bus_state <= BUS_IDLE;
            selected  <= 1'b0;
          end
        end
        BUS_ACTIVE: begin
          // Hold selection for the remaining fields of the cycle
          if (field_left == 5'h01) begin
            bus_state <= BUS_IDLE;
            selected  <= 1'b0;
          end
          field_left <= field_left - 5'h01;
        end
      endcase
    end
  end

  assign o_cycle_selected = selected;

  // Protection decode for program and erase requests
  assign in_top_block = (prog_req.addr[ARRAY_AW-1 -: 4] == TOP_BLOCK_TAG);

  // Hardware locks only exist in hub mode; factory mode is unguarded
  // Refusal uses the settled lock levels, never the raw pins
  always_comb begin
    prog_refused = 1'b0;
    if (!factory_mode) begin
      if (in_top_block) begin
        prog_refused = ~pins.top_sector_lock_n;
      end else begin
        prog_refused = ~pins.write_guard_n;
      end
    end
  end

  // Write launch; a refused request never reaches the array
  // Registered pulse keeps decode glitches off the array start
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      o_write_start   <= 1'b0;
      o_write_blocked <= 1'b0;
      o_write_addr    <= '0;
    end else begin
      o_write_start   <= prog_req.valid & ~prog_refused;
      o_write_blocked <= prog_req.valid & prog_refused;
      // Address moves only for an accepted write
      if (prog_req.valid && !prog_refused) begin
        o_write_addr <= prog_req.addr;
      end
    end
  end

  // Levels assumed held through each write by the system
  // Guard pins are re-read every request, so a drop mid-stream blocks
  // the next request rather than aborting one in flight.

  // Factory address halves follow the pins by select level
  // Each half keeps its value while the other one is loaded
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      row_part <= '0;
      col_part <= '0;
    end else if (factory_mode) begin
      if (pins.row_col_select) begin
        col_part <= pins.addr_pins[COL_W-1:0];
      end else begin
        row_part <= pins.addr_pins;
      end
    end
  end

  // Column half maps to the upper address bits
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      o_pp_address <= '0;
    end else begin
      o_pp_address <= {col_part, row_part};
    end
  end

  // Control register: bus response enable
  // Clearing the enable makes this part ignore every bus cycle
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      control <= CONTROL_RESET;
    end else if (i_reg_wr && i_reg_addr == OFF_CONTROL) begin
      control <= i_reg_wdata;
    end
  end

  // Sticky refusal events; a new event beats a same-cycle clear
  // Write a one to clear a bit; zero bits are left alone
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      events <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (i_reg_wr && i_reg_addr == OFF_EVENTS && i_reg_wdata[i]) begin
          events[i] <= 1'b0;
        end
      end
      if (prog_req.valid && prog_refused && in_top_block) begin
        events[EV_TOP_BIT] <= 1'b1;
      end
      if (prog_req.valid && prog_refused && !in_top_block) begin
        events[EV_MAIN_BIT] <= 1'b1;
      end
    end
  end

  // Snapshot uses settled levels; host keeps them stable meanwhile
  assign snapshot = {3'h0, pins.general_inputs};

  // Status word placed field by field at the package positions
  always_comb begin
    status                       = '0;
    status[ST_STRAP_LSB +: 4]    = pins.strap_select;
    status[ST_MODE_BIT]          = factory_mode;
    status[ST_TOP_LOCK_BIT]      = pins.top_sector_lock_n;
    status[ST_GUARD_BIT]         = pins.write_guard_n;
    status[ST_SEL_BIT]           = selected;
  end

  // Read data stand one cycle after the strobe, only there
  // Zero outside the answer cycle keeps a shared read bus clean
  always_ff @(posedge i_clk) begin
    if (int_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFF_SNAPSHOT: begin
          o_reg_rdata <= snapshot;
        end
        OFF_STATUS: begin
          o_reg_rdata <= status;
        end
        OFF_CONTROL: begin
          o_reg_rdata <= control;
        end
        OFF_EVENTS: begin
          o_reg_rdata <= {6'h00, events};
        end
        default: begin
          // Unmapped addresses read as zero
          o_reg_rdata <= '0;
        end
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule

// ---- core/hub_pin_pkg.sv ----
package hub_pin_pkg;

  // Register port geometry
  localparam int          REG_AW          = 4;
  localparam int          REG_DW          = 8;

  // Register offsets
  localparam logic [3:0]  OFF_SNAPSHOT    = 4'h0;  // input_snapshot_reg
  localparam logic [3:0]  OFF_STATUS      = 4'h4;  // Strap, mode and lock levels
  localparam logic [3:0]  OFF_CONTROL     = 4'h8;  // Bus response enable
  localparam logic [3:0]  OFF_EVENTS      = 4'hc;  // Sticky protection events

  // Status field positions
  localparam int          ST_STRAP_LSB    = 0;
  localparam int          ST_MODE_BIT     = 4;
  localparam int          ST_TOP_LOCK_BIT = 5;
  localparam int          ST_GUARD_BIT    = 6;
  localparam int          ST_SEL_BIT      = 7;

  // Control and event fields
  localparam int          CT_RESPOND_BIT  = 0;
  localparam logic [7:0]  CONTROL_RESET   = 8'h01;
  localparam int          EV_TOP_BIT      = 0;
  localparam int          EV_MAIN_BIT     = 1;

  // Array and factory address geometry
  localparam int          ARRAY_AW        = 20;
  localparam int          ROW_W           = 11;
  localparam int          COL_W           = 9;
  localparam logic [3:0]  TOP_BLOCK_TAG   = 4'hf;  // Highest 64 KB block

  // Hub-bus framing
  localparam logic [3:0]  START_CODE      = 4'hd;
  localparam logic [3:0]  BOOT_STRAP      = 4'h0;
  localparam int          CYCLE_FIELDS    = 17;
  localparam logic [4:0]  CYCLE_REST      = 5'(CYCLE_FIELDS - 2);

  // Pin synchroniser depth
  localparam int          SYNC_STAGES     = 3;

  // All slow pins that cross into the bus clock
  typedef struct packed {
    logic             main_reset_n;
    logic             init_n;
    logic [3:0]       strap_select;
    logic [4:0]       general_inputs;
    logic             top_sector_lock_n;
    logic             write_guard_n;
    logic             interface_select;
    logic             row_col_select;
    logic [ROW_W-1:0] addr_pins;
  } pins_s;

  localparam int          PIN_W           = $bits(pins_s);

  // Program or erase request from the array sequencer
  typedef struct packed {
    logic                valid;
    logic [ARRAY_AW-1:0] addr;
  } prog_req_s;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_TARGET,
    BUS_ACTIVE
  } bus_state_e;

endpackage

// ---- verification/flash_hub_pin_control_properties.sv ----
module flash_hub_pin_control_properties
  import hub_pin_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire logic                i_main_reset_n,
  input wire logic                i_init_n,
  input wire logic [3:0]          i_strap_select,
  input wire logic                i_top_sector_lock_n,
  input wire logic                i_write_guard_n,
  input wire logic                i_frame_strobe_n,
  input wire logic [3:0]          i_nibble_bus,
  input wire logic                i_prog_valid,
  input wire logic [ARRAY_AW-1:0] i_prog_addr,
  input wire logic                o_int_rst,
  input wire logic                o_factory_mode,
  input wire logic                o_cycle_selected,
  input wire logic                o_write_start,
  input wire logic                o_write_blocked,
  input wire logic [ARRAY_AW-1:0] o_write_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Pin filter takes up to four edges, five gives margin
  chk_init_pin_reset: assert property (!i_init_n [*5] |-> o_int_rst)
    else $error("init pin did not reset");
  chk_main_pin_reset: assert property (!i_main_reset_n [*5] |-> o_int_rst)
    else $error("main pin did not reset");
  // Lock pins held long enough to pass the filter
  chk_top_lock_refuse: assert property ((!i_top_sector_lock_n) [*5] ##0 (i_prog_valid
    && !o_int_rst && !o_factory_mode && i_prog_addr[19:16] == TOP_BLOCK_TAG)
    |=> o_write_blocked && !o_write_start) else $error("top write not refused");
  chk_guard_refuse: assert property ((!i_write_guard_n) [*5] ##0 (i_prog_valid
    && !o_int_rst && !o_factory_mode && i_prog_addr[19:16] != TOP_BLOCK_TAG)
    |=> o_write_blocked && !o_write_start) else $error("guarded write not refused");
  // A refused write must leave the write address alone
  chk_blocked_quiet: assert property (o_write_blocked |-> $stable(o_write_addr))
    else $error("blocked write moved address");
  // Selection only after a start field and a matching target
  chk_target_match: assert property ($rose(o_cycle_selected) |->
    $past(i_nibble_bus) == i_strap_select && !$past(i_frame_strobe_n, 2)
    && $past(i_nibble_bus, 2) == START_CODE) else $error("selected without match");
  chk_factory_silent: assert property (o_factory_mode |-> !o_cycle_selected)
    else $error("bus answered in factory mode");
  // Mode may only move while the internal reset is up
  chk_mode_fixed: assert property (!o_int_rst && !$past(o_int_rst)
    |-> $stable(o_factory_mode)) else $error("mode changed in operation");
endmodule

bind flash_hub_pin_control flash_hub_pin_control_properties u_props (.i_clk, .i_rst,
  .i_main_reset_n, .i_init_n, .i_strap_select, .i_top_sector_lock_n, .i_write_guard_n,
  .i_frame_strobe_n, .i_nibble_bus, .i_prog_valid, .i_prog_addr, .o_int_rst,
  .o_factory_mode, .o_cycle_selected, .o_write_start, .o_write_blocked, .o_write_addr);

// ---- verification/hub_host_model.sv ----
module hub_host_model
  import hub_pin_pkg::*;
(
  input  wire logic       i_clk,
  output logic            o_frame_strobe_n,
  output logic [3:0]      o_nibble_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] pat;   // Wander pattern for a released bus
  logic       busy;  // Task owns the bus
  initial begin
    o_frame_strobe_n = 1'b1;
    o_nibble_bus = 4'h0;
    pat = 4'h0;
    busy = 1'b0;
  end
  // Released bus never holds its last value
  always @(posedge i_clk) begin
    if (!busy) begin
      pat <= pat + 4'h5;
      o_nibble_bus <= ~pat;
    end
  end
  // Repeated start fields model a slow host; only the last counts
  task automatic send(input logic [3:0] target, input int starts);
    busy = 1'b1;
    repeat (starts) begin
      @(posedge i_clk);
      o_frame_strobe_n <= 1'b0;
      o_nibble_bus <= START_CODE;
    end
    @(posedge i_clk);
    o_frame_strobe_n <= 1'b1;
    o_nibble_bus <= target;
    @(posedge i_clk);
    busy = 1'b0;
  endtask
endmodule

// ---- verification/flash_hub_pin_control_tb.sv ----
module flash_hub_pin_control_tb
  import hub_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_main_reset_n, i_init_n, i_top_sector_lock_n, i_write_guard_n;
  logic i_interface_select, i_row_col_select, i_frame_strobe_n, i_prog_valid;
  logic i_reg_wr, i_reg_rd, o_int_rst, o_factory_mode, o_cycle_selected;
  logic o_write_start, o_write_blocked;
  logic [3:0] i_strap_select, i_nibble_bus, i_reg_addr;
  logic [4:0] i_general_inputs;
  logic [ROW_W-1:0] i_addr_pins;
  logic [7:0] i_reg_wdata, o_reg_rdata, rd;
  logic [ARRAY_AW-1:0] i_prog_addr, o_write_addr, o_pp_address, last;
  int bad_count = 0;
  int cmp_count = 0;

  flash_hub_pin_control u_dut (.i_clk, .i_rst, .i_main_reset_n, .i_init_n, .i_strap_select,
    .i_general_inputs, .i_top_sector_lock_n, .i_write_guard_n, .i_interface_select,
    .i_row_col_select, .i_addr_pins, .i_frame_strobe_n, .i_nibble_bus, .i_prog_valid,
    .i_prog_addr, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_int_rst,
    .o_factory_mode, .o_cycle_selected, .o_write_start, .o_write_blocked, .o_write_addr,
    .o_pp_address);
  hub_host_model u_host (.i_clk, .o_frame_strobe_n(i_frame_strobe_n),
    .o_nibble_bus(i_nibble_bus));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 rd = o_reg_rdata;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  // Either pin alone must raise and drop the merged reset
  task automatic test_reset_pins;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      if (k == 0) i_init_n <= 1'b0;
      else i_main_reset_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      #1 chk("int_rst", 1'b1, o_int_rst);
      @(posedge i_clk);
      i_init_n <= 1'b1;
      i_main_reset_n <= 1'b1;
      repeat (6) @(posedge i_clk);
      #1 chk("int_rst", 1'b0, o_int_rst);
    end
  endtask
  // Snapshot follows the pins; an unmapped place reads zero
  task automatic test_snapshot;
    logic [4:0] v [3] = '{5'h15, 5'h0a, 5'h1f};
    foreach (v[i]) begin
      @(posedge i_clk);
      i_general_inputs <= v[i];
      repeat (5) @(posedge i_clk);
      reg_rd(OFF_SNAPSHOT);
      chk("snapshot", {3'b000, v[i]}, rd);
    end
    reg_rd(4'h2);
    chk("unmapped", 8'h00, rd);
  endtask
  // Only a matching target owns the cycle, for 15 cycles
  task automatic test_select(input logic [3:0] strap, input logic [3:0] t, input logic hit);
    @(posedge i_clk);
    i_strap_select <= strap;
    repeat (6) @(posedge i_clk);
    u_host.send(t, 2);
    #1 chk("selected", hit, o_cycle_selected);
    repeat (14) @(posedge i_clk);
    #1 chk("selected", hit, o_cycle_selected);
    @(posedge i_clk);
    #1 chk("selected", 1'b0, o_cycle_selected);
  endtask
  // Response enable off silences even a matching target
  task automatic test_control;
    reg_wr(OFF_CONTROL, 8'h00);
    reg_rd(OFF_CONTROL);
    chk("control", 8'h00, rd);
    reg_rd(OFF_STATUS);
    chk("status", 8'h63, rd);
    test_select(4'h3, 4'h3, 1'b0);
    reg_wr(OFF_CONTROL, 8'h01);
    reg_rd(OFF_CONTROL);
    chk("control", 8'h01, rd);
  endtask
  // Every pin pair against both regions of the array
  task automatic test_protect;
    logic blk;
    logic [19:0] a;
    for (int i = 0; i < 8; i++) begin
      a = i[2] ? 20'hf1234 + 20'(i) : 20'h0abcd + 20'(i);
      blk = i[2] ? !i[0] : !i[1];
      @(posedge i_clk);
      i_top_sector_lock_n <= i[0];
      i_write_guard_n <= i[1];
      repeat (5) @(posedge i_clk);
      i_prog_valid <= 1'b1;
      i_prog_addr <= a;
      @(posedge i_clk);
      i_prog_valid <= 1'b0;
      if (!blk) last = a;
      #1 chk("blocked", blk, o_write_blocked);
      chk("start", !blk, o_write_start);
      chk("write_addr", last, o_write_addr);
    end
    reg_rd(OFF_EVENTS);
    chk("events", 8'h03, rd);
    reg_wr(OFF_EVENTS, 8'h03);
    reg_rd(OFF_EVENTS);
    chk("events", 8'h00, rd);
  endtask
  // Factory mode: address pins split by row/column select
  task automatic test_factory;
    @(posedge i_clk);
    i_interface_select <= 1'b1;
    i_top_sector_lock_n <= 1'b0;
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    i_addr_pins <= 11'h5a5;
    repeat (6) @(posedge i_clk);
    #1 chk("factory", 1'b1, o_factory_mode);
    @(posedge i_clk);
    i_row_col_select <= 1'b1;
    i_addr_pins <= 11'h1c3;
    repeat (6) @(posedge i_clk);
    #1 chk("pp_address", {9'h1c3, 11'h5a5}, o_pp_address);
    // Locks do not apply in factory mode, even with the top lock low
    @(posedge i_clk);
    i_prog_valid <= 1'b1;
    i_prog_addr <= 20'hf0000;
    @(posedge i_clk);
    i_prog_valid <= 1'b0;
    #1 chk("start", 1'b1, o_write_start);
    chk("blocked", 1'b0, o_write_blocked);
    test_select(4'h3, 4'h3, 1'b0);
  endtask

  initial begin
    {i_main_reset_n, i_init_n, i_top_sector_lock_n, i_write_guard_n} = 4'hf;
    {i_interface_select, i_row_col_select, i_prog_valid, i_reg_wr, i_reg_rd} = 5'h00;
    {i_strap_select, i_general_inputs, i_addr_pins, i_reg_addr, i_reg_wdata} = '0;
    i_prog_addr = '0;
    last = '0;
    i_rst = 1'b1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    test_reset_pins();
    test_snapshot();
    test_select(BOOT_STRAP, 4'h0, 1'b1);
    test_select(BOOT_STRAP, 4'h5, 1'b0);
    test_select(4'h3, 4'h3, 1'b1);
    test_control();
    test_protect();
    test_factory();
    end_of_test();
  end
  // Whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    end_of_test();
  end
endmodule
